//--- hw/tap_regs.vh
/*
 * constants of the boundary-scan test port: instruction codes,
 * register sizes, identification field positions, reset values.
 * assumes it is included by bare name from the design files.
 */
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// register sizes
`define IR_LEN 8
`define BSR_LEN 113
`define ID_LEN 32

// instruction codes, zero-extended to the register width except bypass, which is all ones
`define INS_EXTEST 8'h00
`define INS_IDCODE 8'h01
`define INS_OUTPUTS_FLOAT_INSTRUCTION 8'h03
`define INS_SAMPLE 8'h05
`define INS_CLAMP 8'h07
`define INS_BYPASS 8'hff

// capture-ir pattern loaded into the shift stage
`define IR_CAPTURE 8'h01

// identification word field positions
`define ID_REV_MSB 31
`define ID_REV_LSB 28
`define ID_DEV_MSB 27
`define ID_DEV_LSB 12
`define ID_MAKER_MSB 11
`define ID_MAKER_LSB 1
`define ID_PRESENT_BIT 0

// reset values
`define IR_RESET `INS_IDCODE
`define BYPASS_CAPTURE 1'b0

// observation stream
`define OBS_WIDTH 2
`define OBS_DEPTH 16

`endif

//--- hw/scan_fifo.v
/*
 * first-word-fall-through fifo with a registered head word.
 * assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module scan_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output reg o_in_ready,
   output reg o_out_valid,
   output reg [WIDTH-1:0] o_out_data,
   input wire i_out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] count_ff;
   reg [AW:0] nxt_count;
   wire push;
   wire pop_out;
   wire load;

   // push when room, move head when storage holds a word and head frees
   assign push = i_in_valid & o_in_ready;
   assign pop_out = o_out_valid & i_out_ready;
   assign load = (count_ff != {(AW+1){1'b0}}) & (~o_out_valid | pop_out);

   // occupancy of the storage array
   always @*
   begin
      nxt_count = count_ff;
      if (push & ~load)
         nxt_count = count_ff + 1'b1;
      else if (load & ~push)
         nxt_count = count_ff - 1'b1;
   end

   // storage writes
   always @(posedge i_clk_sys)
   begin
      if (push)
         mem[wr_ptr_ff] <= i_in_data;
   end

   // pointers, flags and head register
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end
      else
      begin
         count_ff <= nxt_count;
         o_in_ready <= (nxt_count != DEPTH[AW:0]); // honest full
         if (push)
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (load)
         begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
            o_out_data <= mem[rd_ptr_ff];
            o_out_valid <= 1'b1;
         end
         else if (pop_out)
            o_out_valid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

//--- hw/memory_boundary_scan_tap.v
/*
 * boundary-scan test port of the memory device: state controller, instruction, bypass, boundary and id
 * registers, pin override outputs and a stream of shifted-out bits. assumes asynchronous test pins
 * oversampled by i_clk_sys against a test clock of at most an eighth of it; ring inputs are ball levels.
 */
// Summary of operation
// - inputs taken on sampled test-clock rising edge
// - serial output changes on test-clock falling edge
// - output enabled only in shift-ir, shift-dr
// - shift into msb, lsb drives serial output
// - mode-select high five edges resets controller
// - power-up reset floats serial output
// - ir updates in update-ir, resets to identify
// - capture-ir loads binary 01 into lsbs
// - one-bit bypass captures low
// - 113-bit boundary captures ring, then shifts
// - identify loads hardwired 32-bit code
// - eight-bit ir, effective only at update-ir
// - active instruction selects exactly one register
// - external test drives preloaded outputs
// - float instruction uses bypass, floats outputs
// - clamp drives outputs from boundary cells
// - sample snapshots balls, then shifts out
// - bypass routes data through one bit
// - decoder knows 0000, 0001, 0011, 0101, 0111, 1111
// - id word holds revision, device, maker, one
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.vh"

module memory_boundary_scan_tap #(
   parameter [3:0] REVISION = 4'h0,     // arbitrary value
   parameter [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
   parameter [10:0] MAKER_CODE = 11'h123    // arbitrary value
) (
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_tck,
   input wire i_tms,
   input wire i_tdi,
   output reg o_tdo,
   output reg o_tdo_oe,
   input wire [`BSR_LEN-1:0] i_ring_in,
   output reg [`BSR_LEN-1:0] o_ring_out,
   output reg o_ring_override,
   output reg o_outputs_float,
   output reg o_test_reset,
   output reg o_obs_valid,
   output reg [`OBS_WIDTH-1:0] o_obs_data,
   input wire i_obs_ready,
   output reg o_obs_in_ready
);

   // controller states
   localparam [3:0] ST_TLR = 4'h0;
   localparam [3:0] ST_RTI = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SH_DR = 4'h4;
   localparam [3:0] ST_EX1_DR = 4'h5;
   localparam [3:0] ST_PA_DR = 4'h6;
   localparam [3:0] ST_EX2_DR = 4'h7;
   localparam [3:0] ST_UPD_DR = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'ha;
   localparam [3:0] ST_SH_IR = 4'hb;
   localparam [3:0] ST_EX1_IR = 4'hc;
   localparam [3:0] ST_PA_IR = 4'hd;
   localparam [3:0] ST_EX2_IR = 4'he;
   localparam [3:0] ST_UPD_IR = 4'hf;
   // data register selection
   localparam [1:0] SEL_BYPASS = 2'h0;
   localparam [1:0] SEL_BOUND = 2'h1;
   localparam [1:0] SEL_ID = 2'h2;
   wire [`ID_LEN-1:0] id_word;
   reg tck_s1_ff;
   reg tck_s2_ff;
   reg tck_s3_ff;
   reg tms_s1_ff;
   reg tms_s2_ff;
   reg tdi_s1_ff;
   reg tdi_s2_ff;
   reg [`BSR_LEN-1:0] ring_s1_ff;
   reg [`BSR_LEN-1:0] ring_s2_ff;
   wire tck_rise;
   wire tck_fall;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [`IR_LEN-1:0] ir_sh_ff;
   reg [`IR_LEN-1:0] ir_ff;
   reg bypass_ff;
   reg [`BSR_LEN-1:0] bsr_sh_ff;
   reg [`ID_LEN-1:0] id_sh_ff;
   reg [1:0] sel;
   reg serial_bit;
   wire shifting;
   wire obs_fifo_ready;
   wire obs_fifo_valid;
   wire [`OBS_WIDTH-1:0] obs_fifo_data;
   reg obs_push_ff;
   reg [`OBS_WIDTH-1:0] obs_word_ff;

   // identification word
   assign id_word = {REVISION, DEVICE_CODE, MAKER_CODE, 1'b1};

   // two-stage synchronisers for the test pins and the ball levels
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         tck_s1_ff <= 1'b0;
         tck_s2_ff <= 1'b0;
         tck_s3_ff <= 1'b0;
         tms_s1_ff <= 1'b1;
         tms_s2_ff <= 1'b1;
         tdi_s1_ff <= 1'b1;
         tdi_s2_ff <= 1'b1;
         ring_s1_ff <= {`BSR_LEN{1'b0}};
         ring_s2_ff <= {`BSR_LEN{1'b0}};
      end
      else
      begin
         tck_s1_ff <= i_tck;
         tck_s2_ff <= tck_s1_ff;
         tck_s3_ff <= tck_s2_ff;
         tms_s1_ff <= i_tms;
         tms_s2_ff <= tms_s1_ff;
         tdi_s1_ff <= i_tdi;
         tdi_s2_ff <= tdi_s1_ff;
         ring_s1_ff <= i_ring_in;
         ring_s2_ff <= ring_s1_ff;
      end
   end

   // test-clock edges found on the synchronised level
   assign tck_rise = tck_s2_ff & ~tck_s3_ff;
   assign tck_fall = ~tck_s2_ff & tck_s3_ff;
   assign shifting = (state_ff == ST_SH_DR) | (state_ff == ST_SH_IR);

   // sixteen-state controller transitions on mode-select
   always @*
   begin
      case (state_ff)
         ST_TLR: nxt_state = tms_s2_ff ? ST_TLR : ST_RTI;
         ST_RTI: nxt_state = tms_s2_ff ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: nxt_state = tms_s2_ff ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state = tms_s2_ff ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: nxt_state = tms_s2_ff ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: nxt_state = tms_s2_ff ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR: nxt_state = tms_s2_ff ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: nxt_state = tms_s2_ff ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: nxt_state = tms_s2_ff ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: nxt_state = tms_s2_ff ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: nxt_state = tms_s2_ff ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: nxt_state = tms_s2_ff ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: nxt_state = tms_s2_ff ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR: nxt_state = tms_s2_ff ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: nxt_state = tms_s2_ff ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: nxt_state = tms_s2_ff ? ST_SEL_DR : ST_RTI;
         default: nxt_state = ST_TLR;
      endcase
   end

   // instruction decode: one data register on the serial path
   always @*
   begin
      case (ir_ff)
         `INS_EXTEST: sel = SEL_BOUND;
         `INS_SAMPLE: sel = SEL_BOUND;
         `INS_IDCODE: sel = SEL_ID;
         `INS_OUTPUTS_FLOAT_INSTRUCTION: sel = SEL_BYPASS;
         `INS_CLAMP: sel = SEL_BYPASS;
         `INS_BYPASS: sel = SEL_BYPASS;
         default: sel = SEL_BYPASS; // reserved codes fall back to bypass
      endcase
   end

   // bit presented on the serial output: lsb of the active stage
   always @*
   begin
      if (state_ff == ST_SH_IR)
         serial_bit = ir_sh_ff[0];
      else
      begin
         case (sel)
            SEL_BOUND: serial_bit = bsr_sh_ff[0];
            SEL_ID: serial_bit = id_sh_ff[0];
            default: serial_bit = bypass_ff;
         endcase
      end
   end

   // controller state and instruction path, stepped on rising edges
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         state_ff <= ST_TLR;
         ir_sh_ff <= `IR_RESET;
         ir_ff <= `IR_RESET;
      end
      else if (tck_rise)
      begin
         state_ff <= nxt_state;
         case (state_ff)
            ST_TLR: ir_ff <= `IR_RESET;
            ST_CAP_IR: ir_sh_ff <= `IR_CAPTURE;
            ST_SH_IR: ir_sh_ff <= {tdi_s2_ff, ir_sh_ff[`IR_LEN-1:1]};
            ST_UPD_IR: ir_ff <= ir_sh_ff;
            default: if (nxt_state == ST_TLR) ir_ff <= `IR_RESET; // identify on entry to reset
         endcase
      end
   end

   // data registers: capture and shift of the selected one only
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         bypass_ff <= `BYPASS_CAPTURE;
         bsr_sh_ff <= {`BSR_LEN{1'b0}};
         id_sh_ff <= {`ID_LEN{1'b0}};
      end
      else if (tck_rise)
      begin
         if (state_ff == ST_CAP_DR)
         begin
            case (sel)
               SEL_BOUND: bsr_sh_ff <= ring_s2_ff;
               SEL_ID: id_sh_ff <= id_word;
               default: bypass_ff <= `BYPASS_CAPTURE;
            endcase
         end
         else if (state_ff == ST_SH_DR)
         begin
            case (sel)
               SEL_BOUND: bsr_sh_ff <= {tdi_s2_ff, bsr_sh_ff[`BSR_LEN-1:1]};
               SEL_ID: id_sh_ff <= {tdi_s2_ff, id_sh_ff[`ID_LEN-1:1]};
               default: bypass_ff <= tdi_s2_ff;
            endcase
         end
      end
   end

   // ball drivers: update stage and override modes
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_ring_out <= {`BSR_LEN{1'b0}};
         o_ring_override <= 1'b0;
         o_outputs_float <= 1'b0;
      end
      else if (tck_rise)
      begin
         if (nxt_state == ST_TLR) // cleared on the edge that enters reset
         begin
            o_ring_override <= 1'b0; // test reset leaves the memory alone
            o_outputs_float <= 1'b0;
         end
         else if (state_ff == ST_UPD_DR && sel == SEL_BOUND)
            o_ring_out <= bsr_sh_ff; // preload or test vector latched
         else if (state_ff == ST_UPD_IR)
         begin
            o_ring_override <= (ir_sh_ff == `INS_EXTEST) | (ir_sh_ff == `INS_CLAMP);
            o_outputs_float <= (ir_sh_ff == `INS_OUTPUTS_FLOAT_INSTRUCTION);
         end
      end
   end

   // serial output and its enable, changed only on falling edges
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
         o_test_reset <= 1'b1;
      end
      else
      begin
         o_test_reset <= (state_ff == ST_TLR);
         if (tck_fall)
         begin
            o_tdo <= serial_bit;
            o_tdo_oe <= shifting;
         end
      end
   end

   // every bit leaving the shift stage is pushed to the observation stream while it has room
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         obs_push_ff <= 1'b0;
         obs_word_ff <= {`OBS_WIDTH{1'b0}};
      end
      else
      begin
         obs_push_ff <= tck_rise & shifting;
         if (tck_rise & shifting)
            obs_word_ff <= {state_ff == ST_SH_IR, serial_bit};
      end
   end

   // bits are dropped while the stream is full; the test clock cannot wait
   scan_fifo #(
      .WIDTH(`OBS_WIDTH),
      .DEPTH(`OBS_DEPTH),
      .AW(4)
   ) u_obs_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_in_valid(obs_push_ff),
      .i_in_data(obs_word_ff),
      .o_in_ready(obs_fifo_ready),
      .o_out_valid(obs_fifo_valid),
      .o_out_data(obs_fifo_data),
      .i_out_ready(i_obs_ready)
   );

   // stream outputs taken from the fifo's registers
   always @*
   begin
      o_obs_valid = obs_fifo_valid;
      o_obs_data = obs_fifo_data;
      o_obs_in_ready = obs_fifo_ready;
   end

endmodule

`default_nettype wire

//--- tb/tap_props.sv
/* port assertions of the boundary-scan port.
   assumes a bind into the design top, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.vh"
module tap_props (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic o_tdo,
   input wire logic o_tdo_oe,
   input wire logic o_ring_override,
   input wire logic o_outputs_float,
   input wire logic o_test_reset,
   input wire logic o_obs_valid,
   input wire logic [`OBS_WIDTH-1:0] o_obs_data,
   input wire logic i_obs_ready
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic tck_q_ff;
   logic [2:0] tms_cnt_ff;
   // counts test-clock rises seen with mode-select high
   always @(posedge i_clk_sys)
   begin
      tck_q_ff <= i_tck;
      if (i_rst || (i_tck && !tck_q_ff && !i_tms))
         tms_cnt_ff <= 3'h0;
      else if (i_tck && !tck_q_ff && tms_cnt_ff != 3'h5)
         tms_cnt_ff <= tms_cnt_ff + 3'h1;
   end
   a_reset_float: assert property (disable iff (1'b0) i_rst |=> !o_tdo_oe && o_test_reset)
      else $error("serial output not floated by reset");
   a_tdo_on_fall: assert property ($changed(o_tdo) |-> !$past(i_tck) && !$past(i_tck, 3))
      else $error("serial output moved outside test-clock low");
   a_oe_on_fall: assert property ($changed(o_tdo_oe) |-> !$past(i_tck) && !$past(i_tck, 3))
      else $error("output enable moved outside test-clock low");
   a_oe_off_reset: assert property (o_test_reset |-> !o_tdo_oe)
      else $error("serial output driven in reset state");
   a_five_tms: assert property (tms_cnt_ff == 3'h5 |-> ##[0:8] o_test_reset)
      else $error("five mode-select rises did not reset");
   a_one_path: assert property (!(o_ring_override && o_outputs_float))
      else $error("override and float both active");
   a_reset_clears: assert property (o_test_reset ##1 o_test_reset |-> !o_ring_override && !o_outputs_float)
      else $error("pin control kept in reset state");
   a_obs_hold: assert property (o_obs_valid && !i_obs_ready |=> o_obs_valid && $stable(o_obs_data))
      else $error("stream word dropped while stalled");
endmodule
`default_nettype wire

//--- tb/jtag_tester.sv
/* board test controller model on the four-wire port.
   assumes a 40 mhz i_clk_sys; test clock period is 200 ns. */
`timescale 1ns/1ps
`default_nettype none
module jtag_tester (
   input wire logic i_clk_sys,
   input wire logic i_tdo,
   input wire logic i_tdo_oe,
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi
);
   logic [127:0] sh_out;
   wire tdo_line;
   // a released pin has no pull: the model sees the inverse, so a late sample fails
   assign tdo_line = i_tdo_oe ? i_tdo : ~i_tdo;
   // no memory-side pins here: impedance select mode bit stays low, memory idle
   // test clock stands low, data lines pulled up
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys) #1;
   endtask
   // one test-clock period, output taken just before the rise
   task automatic clk_bit(input logic ms, input logic di, output logic q);
      tick(2);
      o_tms = ms;
      o_tdi = di;
      tick(2);
      q = tdo_line;
      o_tck = 1'b1;
      tick(4);
      o_tck = 1'b0;
   endtask
   // walks the controller by a mode-select pattern, bit 0 first
   task automatic walk(input logic [7:0] pat, input int n);
      logic q;
      for (int i = 0; i < n; i++)
         clk_bit(pat[i], 1'b1, q);
   endtask
   // from idle: n-bit scan of ir or dr, then update and idle
   task automatic scan(input logic ir, input logic [127:0] din, input int n);
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++)
         clk_bit(i == n - 1, din[i], sh_out[i]);
      walk(8'h01, 2);
   endtask
endmodule
`default_nettype wire

//--- tb/memory_boundary_scan_tap_tb.sv
/* self-checking bench of the boundary-scan port.
   assumes the design header on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module memory_boundary_scan_tap_tb;
   localparam logic [3:0] REV = 4'h5; // arbitrary value
   localparam logic [15:0] DEV = 16'h2c3a; // arbitrary value
   localparam logic [10:0] MAKER = 11'h2b1; // arbitrary value
   localparam logic [112:0] RING = {17'h1a5c3, 32'h9e3779b9, 32'h0f1e2d3c, 32'hc001d00d};
   logic i_clk_sys;
   logic i_rst;
   logic i_obs_ready;
   logic [`BSR_LEN-1:0] i_ring_in;
   wire tck, tms, tdi, tdo, tdo_oe, ovr, flt, trst, obs_valid, obs_in_ready;
   wire [`BSR_LEN-1:0] ring_out;
   wire [`OBS_WIDTH-1:0] obs_data;
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   memory_boundary_scan_tap #(.REVISION(REV), .DEVICE_CODE(DEV), .MAKER_CODE(MAKER)) dut (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ring_in(i_ring_in), .o_ring_out(ring_out),
      .o_ring_override(ovr), .o_outputs_float(flt), .o_test_reset(trst), .o_obs_valid(obs_valid),
      .o_obs_data(obs_data), .i_obs_ready(i_obs_ready), .o_obs_in_ready(obs_in_ready));
   jtag_tester jt (.i_clk_sys(i_clk_sys), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
   // system clock, 25 ns
   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys) #1;
   endtask
   task automatic summarize;
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // state right after power-up reset
   task automatic t_reset;
      `CHK({tdo_oe, trst, ovr, flt}, 4'h4)
   endtask
   // identification word from idle, lsb first
   task automatic t_ident;
      jt.walk(8'h00, 1);
      jt.scan(1'b0, '1, 32);
      `CHK(jt.sh_out[31:0], {REV, DEV, MAKER, 1'b1})
   endtask
   // ball snapshot with the stream stalled until it refuses
   task automatic t_sample;
      int n;
      jt.scan(1'b1, `INS_SAMPLE, 8);
      `CHK(jt.sh_out[7:0], `IR_CAPTURE)
      tick(4);
      i_obs_ready = 1'b0;
      jt.scan(1'b0, ~RING, `BSR_LEN);
      `CHK(jt.sh_out[112:0], RING)
      `CHK(ring_out, ~RING)
      `CHK({ovr, obs_in_ready}, 2'b00)
      i_obs_ready = 1'b1;
      for (int k = 0; k < `OBS_DEPTH; k++)
      begin
         n = 0;
         while (obs_valid !== 1'b1 && n < 20)
         begin
            tick(1);
            n++;
         end
         `CHK(obs_data, {1'b0, RING[k]})
         tick(1);
      end
   endtask
   // external test drives the preloaded vector, captures the balls
   task automatic t_extest;
      jt.scan(1'b1, `INS_EXTEST, 8);
      `CHK({ovr, flt}, 2'b10)
      `CHK(ring_out, ~RING)
      jt.scan(1'b0, RING, `BSR_LEN);
      `CHK(jt.sh_out[112:0], RING)
      `CHK(ring_out, RING)
   endtask
   // codes that put the single bypass bit in the path
   task automatic t_bypass;
      logic [7:0] code [4] = '{`INS_BYPASS, `INS_OUTPUTS_FLOAT_INSTRUCTION, `INS_BYPASS, `INS_CLAMP};
      logic [1:0] pins [4] = '{2'b00, 2'b01, 2'b00, 2'b10};
      for (int k = 0; k < 4; k++)
      begin
         jt.scan(1'b1, code[k], 8);
         `CHK({ovr, flt}, pins[k])
         jt.scan(1'b0, 4'hb, 4);
         `CHK(jt.sh_out[3:0], 4'h6)
      end
   endtask
   // five high mode-select rises bring back reset and identify
   task automatic t_tms_reset;
      jt.walk(8'h1f, 5);
      tick(8);
      `CHK({trst, ovr, flt}, 3'b100)
      t_ident();
   endtask
   // main sequence
   initial
   begin
      i_rst = 1'b1;
      i_obs_ready = 1'b1;
      i_ring_in = RING;
      tick(16);
      i_rst = 1'b0;
      tick(4);
      t_reset();
      t_ident();
      t_sample();
      t_extest();
      t_bypass();
      t_tms_reset();
      summarize();
   end
   // hang guard
   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end
endmodule
bind memory_boundary_scan_tap tap_props chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms),
   .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_ring_override(o_ring_override), .o_outputs_float(o_outputs_float),
   .o_test_reset(o_test_reset), .o_obs_valid(o_obs_valid), .o_obs_data(o_obs_data), .i_obs_ready(i_obs_ready));
`default_nettype wire
